/* rtl/vtl_pkg.sv */
// Package: constants and carrier types of the vector table lookup block
package vtl_pkg;
  // Address and table geometry
  localparam int ADDR_W = 21;
  localparam int NUM_W = 7;
  localparam logic [NUM_W-1:0] NUM_SRC = 7'h44;
  localparam int ISR_SHIFT = 2;
  localparam logic [ADDR_W-1:0] BASE_RST = 21'h000008;
  localparam logic [ADDR_W-1:0] LOW_PRI_OFS = 21'h000010;
  // Executable flash limits, plain defaults
  localparam logic [ADDR_W-1:0] FLASH_LAST = 21'h00ffff;
  localparam logic [ADDR_W-1:0] STORE_FIRST = 21'h00ff80;
  // Register offsets
  localparam logic [3:0] R_BASE_L = 4'h0;
  localparam logic [3:0] R_BASE_H = 4'h1;
  localparam logic [3:0] R_BASE_U = 4'h2;
  localparam logic [3:0] R_CAP_L = 4'h3;
  localparam logic [3:0] R_CAP_H = 4'h4;
  localparam logic [3:0] R_CAP_U = 4'h5;
  localparam logic [3:0] R_CFG = 4'h6;
  localparam logic [3:0] R_RCAUSE = 4'h7;
  localparam logic [3:0] R_STS = 4'h8;
  localparam logic [3:0] R_MASK = 4'h9;
  localparam logic [3:0] R_STATE = 4'ha;
  // Field positions and masks
  localparam int CFG_MVEC = 0;
  localparam int CFG_STORE_EN = 1;
  localparam logic [7:0] CFG_MASK = 8'h03;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int RC_VIOL_FLAG = 0;
  localparam logic [7:0] RC_MASK = 8'h01;
  localparam logic [7:0] RC_RST = 8'h01;
  localparam int SB_ACCEPT = 0;
  localparam int SB_VECTOR = 1;
  localparam int SB_VIOL = 2;
  localparam logic [7:0] SB_MASK = 8'h07;
  // Request from the priority logic
  typedef struct packed {
    logic valid;
    logic [NUM_W-1:0] num;
  } vtl_req_t;
  // Vector handed to the core
  typedef struct packed {
    logic valid;
    logic high;
    logic [ADDR_W-1:0] addr;
  } vtl_vec_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_HALT = 3'b100
  } vtl_state_t;
endpackage : vtl_pkg

/* rtl/vtl_calc.sv */
// Entry location arithmetic for legacy and multi-vector modes
`timescale 1ns/100ps
`default_nettype none
module vtl_calc
  import vtl_pkg::*;
(
  input wire logic [ADDR_W-1:0] base,
  input wire logic multi,
  input wire logic high,
  input wire logic [NUM_W-1:0] num,
  output logic [ADDR_W-1:0] entry
);
  // Priority only matters in legacy mode; the number decides otherwise
  function automatic logic [ADDR_W-1:0] entry_loc(
    input logic [ADDR_W-1:0] b,
    input logic m,
    input logic h,
    input logic [NUM_W-1:0] n
  );
    if (m)
      entry_loc = b + ADDR_W'({n, 1'b0});
    else if (h)
      entry_loc = b;
    else
      entry_loc = b + LOW_PRI_OFS;
  endfunction : entry_loc

  assign entry = entry_loc(base, multi, high, num);
endmodule : vtl_calc
`default_nettype wire

/* rtl/vtl_region.sv */
// Executable-region check for table entries and routine addresses
`timescale 1ns/100ps
`default_nettype none
module vtl_region
  import vtl_pkg::*;
(
  input wire logic store_en,
  input wire logic [ADDR_W-1:0] entry,
  input wire logic [ADDR_W-1:0] isr,
  output logic entry_ok,
  output logic isr_ok
);
  // Storage area is data only while enabled
  function automatic logic is_exec(
    input logic [ADDR_W-1:0] a,
    input logic prot
  );
    is_exec = (a <= FLASH_LAST) && !(prot && (a >= STORE_FIRST));
  endfunction : is_exec

  // Both bytes of the entry word must be fetchable
  assign entry_ok = is_exec(entry, store_en) && is_exec(entry + 21'h000001, store_en);
  assign isr_ok = is_exec(isr, store_en);
endmodule : vtl_region
`default_nettype wire

/* rtl/vtl_lookup.sv */
// Vector table lookup: accepts requests, forms, fetches and checks vectors
`timescale 1ns/100ps
`default_nettype none
module vtl_lookup
  import vtl_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] rdata_q,
  input wire vtl_req_t hi_req,
  input wire vtl_req_t lo_req,
  output logic accept_q,
  output logic accept_high_q,
  output logic fetch_req_q,
  output logic [ADDR_W-1:0] fetch_addr_q,
  input wire logic fetch_ack,
  input wire logic [15:0] fetch_data,
  output vtl_vec_t vec_q,
  output logic reset_req_q,
  output logic irq_q
);
  vtl_state_t state_q;
  vtl_state_t state_d;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] cap_q;
  logic [7:0] cfg_q;
  logic [7:0] rc_q;
  logic [7:0] sts_q;
  logic [7:0] sts_d;
  logic [7:0] mask_q;
  logic [7:0] sts_set_w;
  logic [7:0] sts_clr_w;
  logic [7:0] rdata_d;
  logic [ADDR_W-1:0] entry_w;
  logic [ADDR_W-1:0] isr_w;
  logic entry_ok_w;
  logic isr_ok_w;
  logic sel_high;
  logic [NUM_W-1:0] sel_num;
  logic any_w;
  logic num_ok_w;
  logic take_w;
  logic bad_entry_w;
  logic done_w;
  logic bad_isr_w;
  logic viol_w;
  logic multi_w;

  // Software-owned base, mode and mask
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      base_q <= BASE_RST;
      cfg_q <= CFG_RST;
      mask_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        R_BASE_L: base_q[7:0] <= reg_wdata;
        R_BASE_H: base_q[15:8] <= reg_wdata;
        R_BASE_U: base_q[20:16] <= reg_wdata[4:0];
        R_CFG: cfg_q <= reg_wdata & CFG_MASK;
        R_MASK: mask_q <= reg_wdata & SB_MASK;
        default: ;
      endcase
    end
  end

  assign multi_w = cfg_q[CFG_MVEC];

  // High request wins; in legacy mode it also picks the location, base or base plus LOW_PRI_OFS
  assign sel_high = hi_req.valid;
  assign sel_num = hi_req.valid ? hi_req.num : lo_req.num;
  assign any_w = hi_req.valid | lo_req.valid;
  // Numbers past the table are ignored rather than read off its end
  assign num_ok_w = !multi_w || (sel_num < NUM_SRC);

  vtl_calc u_calc (
    .base(base_q),
    .multi(multi_w),
    .high(sel_high),
    .num(sel_num),
    .entry(entry_w)
  );

  // Fetched word is the routine address divided by four
  assign isr_w = ADDR_W'(fetch_data) << ISR_SHIFT;

  vtl_region u_region (
    .store_en(cfg_q[CFG_STORE_EN]),
    .entry(entry_w),
    .isr(isr_w),
    .entry_ok(entry_ok_w),
    .isr_ok(isr_ok_w)
  );

  // Decisions of the current cycle
  assign take_w = (state_q == ST_IDLE) && any_w && num_ok_w;
  assign bad_entry_w = take_w && !entry_ok_w;
  assign done_w = (state_q == ST_FETCH) && fetch_ack;
  assign bad_isr_w = done_w && !isr_ok_w;
  assign viol_w = bad_entry_w || bad_isr_w;

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (bad_entry_w)
          state_d = ST_HALT;
        else if (take_w && multi_w)
          state_d = ST_FETCH;
      end
      ST_FETCH:
      begin
        if (bad_isr_w)
          state_d = ST_HALT;
        else if (done_w)
          state_d = ST_IDLE;
      end
      // Halt holds until the device reset comes back in
      ST_HALT: state_d = ST_HALT;
      default: state_d = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Accept strobe and capture, registered: seen the cycle after the choice
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      accept_q <= 1'b0;
      accept_high_q <= 1'b0;
      cap_q <= '0;
    end
    else
    begin
      accept_q <= take_w;
      if (take_w)
      begin
        accept_high_q <= sel_high;
        cap_q <= entry_w;
      end
    end
  end

  // Flash fetch request, held until acknowledged
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fetch_req_q <= 1'b0;
      fetch_addr_q <= '0;
    end
    else if (take_w && multi_w && entry_ok_w)
    begin
      fetch_req_q <= 1'b1;
      fetch_addr_q <= entry_w;
    end
    else if (done_w)
      fetch_req_q <= 1'b0;
  end

  // Vector to the core: one-cycle pulse
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      vec_q <= '0;
    else
    begin
      vec_q.valid <= 1'b0;
      if (take_w && !multi_w && entry_ok_w)
      begin
        vec_q.valid <= 1'b1;
        vec_q.high <= sel_high;
        vec_q.addr <= entry_w;
      end
      else if (done_w && isr_ok_w)
      begin
        vec_q.valid <= 1'b1;
        vec_q.high <= accept_high_q;
        vec_q.addr <= isr_w;
      end
    end
  end

  // Reset request stays up; the device reset clears it
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      reset_req_q <= 1'b0;
    else if (viol_w)
      reset_req_q <= 1'b1;
  end

  // Reset cause: hardware clear beats a software write
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rc_q <= RC_RST;
    else if (viol_w)
      rc_q[RC_VIOL_FLAG] <= 1'b0;
    else if (reg_wr && reg_addr == R_RCAUSE)
      rc_q <= reg_wdata & RC_MASK;
  end

  // Sticky events; a new event wins over a write-one clear
  always_comb
  begin
    sts_set_w = 8'h00;
    sts_set_w[SB_ACCEPT] = take_w;
    sts_set_w[SB_VECTOR] = (take_w && !multi_w && entry_ok_w) || (done_w && isr_ok_w);
    sts_set_w[SB_VIOL] = viol_w;
    sts_clr_w = (reg_wr && reg_addr == R_STS) ? reg_wdata : 8'h00;
    sts_d = (sts_q & ~sts_clr_w) | sts_set_w;
  end

  // Status and interrupt line
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sts_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & mask_q);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (reg_addr)
      R_BASE_L: rdata_d = base_q[7:0];
      R_BASE_H: rdata_d = base_q[15:8];
      R_BASE_U: rdata_d = {3'h0, base_q[20:16]};
      R_CAP_L: rdata_d = cap_q[7:0];
      R_CAP_H: rdata_d = cap_q[15:8];
      R_CAP_U: rdata_d = {3'h0, cap_q[20:16]};
      R_CFG: rdata_d = cfg_q;
      R_RCAUSE: rdata_d = rc_q;
      R_STS: rdata_d = sts_q;
      R_MASK: rdata_d = mask_q;
      R_STATE: rdata_d = {5'h00, state_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= reg_rd ? rdata_d : 8'h00;
  end

  // Checks on the design's own outputs
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_capture_on_accept: assert property (
    accept_q |-> cap_q == $past(entry_w))
    else $error("capture register missed the accepted entry");

  a_legacy_high_vec: assert property (
    take_w && !multi_w && sel_high && entry_ok_w |=> vec_q.valid && vec_q.addr == $past(base_q))
    else $error("legacy high vector not at base");

  a_legacy_low_vec: assert property (
    take_w && !multi_w && !sel_high && entry_ok_w
      |=> vec_q.valid && vec_q.addr == $past(base_q) + 21'h000010)
    else $error("legacy low vector not sixteen above base");

  a_multi_entry_loc: assert property (
    $rose(fetch_req_q) |-> fetch_addr_q == $past(base_q) + ADDR_W'({$past(sel_num), 1'b0}))
    else $error("table entry location wrong");

  a_isr_shift_two: assert property (
    (state_q == ST_FETCH) && fetch_ack && isr_ok_w
      |=> vec_q.valid && vec_q.addr == {3'h0, $past(fetch_data), 2'b00})
    else $error("routine address not entry shifted by two");

  a_viol_resets_all: assert property (
    viol_w |=> reset_req_q && !rc_q[RC_VIOL_FLAG] && sts_q[SB_VIOL] && state_q == ST_HALT)
    else $error("violation did not reset and clear flag");

  a_high_wins_pick: assert property (
    take_w && hi_req.valid && lo_req.valid |=> accept_q && accept_high_q)
    else $error("high request lost to low one");

  a_fetch_in_flash: assert property (
    fetch_req_q |-> fetch_addr_q <= FLASH_LAST)
    else $error("fetch outside program flash");

  a_num_in_table: assert property (
    (state_q == ST_IDLE) && multi_w && !hi_req.valid && lo_req.valid && (lo_req.num >= NUM_SRC)
      |=> !accept_q && !fetch_req_q)
    else $error("accepted source past table end");

  a_fetch_bounded: assert property (
    take_w && multi_w && entry_ok_w |=> fetch_req_q && accept_q)
    else $error("fetch not raised the cycle after accept");

  c_legacy_vector: cover property (take_w && !multi_w ##1 vec_q.valid);
  c_multi_vector: cover property ($rose(fetch_req_q) ##[1:20] vec_q.valid);
  c_violation: cover property ($rose(reset_req_q));
  c_both_pending: cover property (take_w && hi_req.valid && lo_req.valid);
endmodule : vtl_lookup
`default_nettype wire

/* verif/vtl_flash_model.sv */
// Flash read port model answering table-entry fetches
`timescale 1ns/100ps
`default_nettype none
module vtl_flash_model
  import vtl_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic [3:0] delay,
  output logic fetch_ack,
  output logic [15:0] fetch_data
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_q;
  // One word per two byte locations; data toggles when not valid
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fetch_ack <= 1'h0;
      fetch_data <= 16'h0000;
      wait_q <= 4'h0;
    end
    else if (fetch_req && !fetch_ack && wait_q >= delay)
    begin
      fetch_ack <= 1'h1;
      fetch_data <= mem[fetch_addr[8:1]];
      wait_q <= 4'h0;
    end
    else
    begin
      fetch_ack <= 1'h0;
      fetch_data <= ~fetch_data; // Stale data must never look valid
      wait_q <= (fetch_req && !fetch_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : vtl_flash_model
`default_nettype wire

/* verif/vtl_lookup_tb_top.sv */
// Self-checking bench for the vector table lookup block
`timescale 1ns/100ps
`default_nettype none
module vtl_lookup_tb_top
  import vtl_pkg::*;
();
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  vtl_req_t hi_req = '0;
  vtl_req_t lo_req = '0;
  logic [3:0] delay = 4'h0;
  logic [7:0] rdata_q;
  logic accept_q, accept_high_q, fetch_req_q, fetch_ack, reset_req_q, irq_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic [15:0] fetch_data;
  vtl_vec_t vec_q;
  int failures = 0;
  int n_tests = 0;
  // 50 MHz system clock
  always #10 clock = ~clock;
  vtl_lookup DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .rdata_q(rdata_q),
    .hi_req(hi_req), .lo_req(lo_req), .accept_q(accept_q), .accept_high_q(accept_high_q),
    .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .vec_q(vec_q), .reset_req_q(reset_req_q), .irq_q(irq_q));
  vtl_flash_model flash (.clock(clock), .sys_rst(sys_rst), .fetch_req(fetch_req_q),
    .fetch_addr(fetch_addr_q), .delay(delay), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data));
  // Verdict and end of run
  task automatic test_done;
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Compare seen against expected, four-state exact
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Single-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr
  // Register read; data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 chk($sformatf("reg %h", a), rdata_q, exp);
  endtask : rdc
  // Base is split over three byte registers
  task automatic wbase(input logic [ADDR_W-1:0] b);
    wr(R_BASE_L, b[7:0]);
    wr(R_BASE_H, b[15:8]);
    wr(R_BASE_U, {3'h0, b[20:16]});
  endtask : wbase
  task automatic do_reset;
    sys_rst <= 1'h1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
  endtask : do_reset
  // One-cycle request, sampled in the cycle after it is taken
  task automatic send(input logic hi, input logic [NUM_W-1:0] n);
    @(posedge clock);
    if (hi)
      hi_req <= '{1'h1, n};
    else
      lo_req <= '{1'h1, n};
    @(posedge clock);
    hi_req <= '0;
    lo_req <= '0;
    #1;
  endtask : send
  // Bounded wait for a vector or a reset request
  task automatic wait_out;
    for (int i = 0; i < 20; i++)
    begin
      if (vec_q.valid === 1'h1 || reset_req_q === 1'h1)
        break;
      @(posedge clock);
      #1;
    end
  endtask : wait_out
  task automatic t_reset;
    rdc(R_BASE_L, 8'h08);
    rdc(R_BASE_H, 8'h00);
    rdc(R_BASE_U, 8'h00);
    rdc(R_CFG, 8'h00);
    rdc(R_RCAUSE, 8'h01);
    wr(R_RCAUSE, 8'h00);
    rdc(R_RCAUSE, 8'h00);
    rdc(R_STATE, 8'h01);
    rdc(4'hf, 8'h00);
  endtask : t_reset
  // Legacy vectors, both priorities, moved base
  task automatic t_legacy;
    send(1'h1, 7'h00);
    chk("accept", accept_q, 1'h1);
    chk("vec hi", vec_q, {9'h000, 2'h3, 21'h000008});
    send(1'h0, 7'h33);
    chk("vec lo", vec_q, {9'h000, 2'h2, 21'h000018});
    @(posedge clock);
    hi_req <= '{1'h1, 7'h02};
    lo_req <= '{1'h1, 7'h03};
    @(posedge clock);
    hi_req <= '0;
    #1 chk("both hi", vec_q, {9'h000, 2'h3, 21'h000008});
    chk("hi flag", accept_high_q, 1'h1);
    @(posedge clock);
    lo_req <= '0;
    #1 chk("both lo", vec_q, {9'h000, 2'h2, 21'h000018});
    chk("lo flag", accept_high_q, 1'h0);
    wbase(21'h000400);
    send(1'h0, 7'h01);
    chk("vec moved", vec_q, {9'h000, 2'h2, 21'h000410});
    wr(R_CAP_L, 8'h55); // Read-only, must be ignored
    rdc(R_CAP_L, 8'h10);
    rdc(R_CAP_H, 8'h04);
    rdc(R_CAP_U, 8'h00);
  endtask : t_legacy
  // Status sticky bits, mask and interrupt level
  task automatic t_irq;
    rdc(R_STS, 8'h03);
    chk("irq masked", irq_q, 1'h0);
    wr(R_MASK, 8'h02);
    rdc(R_MASK, 8'h02);
    repeat (2) @(posedge clock);
    #1 chk("irq set", irq_q, 1'h1);
    wr(R_STS, 8'h02);
    repeat (2) @(posedge clock);
    #1 chk("irq clr", irq_q, 1'h0);
    rdc(R_STS, 8'h01);
    wr(R_STS, 8'h01);
    wr(R_MASK, 8'h00);
    rdc(R_STS, 8'h00);
  endtask : t_irq
  // Multi-vector fetch with table base 0x100
  task automatic mcase(input logic hi, input logic [6:0] n, input logic [15:0] d,
    input logic [3:0] dly);
    flash.mem[8'h80 + n] = d;
    delay <= dly;
    send(hi, n);
    chk("fetch req", fetch_req_q, 1'h1);
    chk("fetch addr", fetch_addr_q, 32'(21'h000100 + {n, 1'h0}));
    wait_out;
    chk("vec multi", vec_q, {9'h000, 1'h1, hi, 3'h0, d, 2'h0});
    rdc(R_CAP_L, {n, 1'h0});
    rdc(R_CAP_H, 8'h01);
  endtask : mcase
  task automatic t_multi;
    wr(R_CFG, 8'h01);
    wbase(21'h000100);
    mcase(1'h0, 7'h05, 16'h0123, 4'h0);
    mcase(1'h1, 7'h05, 16'h0234, 4'h3);
    mcase(1'h1, 7'h43, 16'h3fdf, 4'h1);
    mcase(1'h0, 7'h00, 16'h3fe0, 4'h2);
    send(1'h0, 7'h44);
    chk("accept 68", accept_q, 1'h0);
  endtask : t_multi
  // Bad entry location or bad fetched routine address leads to reset request and cleared flag
  task automatic t_viol(input logic [7:0] cfg, input logic [ADDR_W-1:0] b,
    input logic [6:0] n, input logic [15:0] d);
    logic [8:0] ix;
    ix = b[8:0] + {n, 1'h0};
    flash.mem[ix[8:1]] = d;
    do_reset;
    wr(R_CFG, cfg);
    wbase(b);
    send(1'h0, n);
    wait_out;
    chk("reset req", reset_req_q, 1'h1);
    chk("no vec", vec_q.valid, 1'h0);
    rdc(R_RCAUSE, 8'h00);
    rdc(R_STS, 8'h05);
    rdc(R_STATE, 8'h04);
  endtask : t_viol
  initial
  begin
    do_reset;
    t_reset;
    t_legacy;
    t_irq;
    t_multi;
    t_viol(8'h01, 21'h000100, 7'h01, 16'h4000);
    t_viol(8'h03, 21'h000100, 7'h02, 16'h3fe0);
    t_viol(8'h01, 21'h00fffe, 7'h01, 16'h0001);
    t_viol(8'h03, 21'h00ff80, 7'h00, 16'h0001);
    do_reset;
    rdc(R_RCAUSE, 8'h01);
    chk("reset req off", reset_req_q, 1'h0);
    test_done;
  end
  // Watchdog, well beyond the expected run length
  initial
  begin
    #100000;
    failures++;
    test_done;
  end
endmodule : vtl_lookup_tb_top
`default_nettype wire
